// ### logic/gpc_port.sv
`timescale 1ns/10ps
`include "gpc_consts.svh"
// Summary of operation
// - Eight-bit two-way port with one direction bit per pin.
// - Direction 1 floats the pin driver; 0 drives it from the latch.
// - Clearing option bit 7 turns on all pull-ups together.
// - A pin set as output has its pull-up off regardless.
// - Pull-ups are off after reset.
// - Only upper four pins, and only inputs, take part in change detect.
// - Each watched pin compares against a reference taken at last port read or write.
// - Mismatches of the four pins are ORed into one change condition.
// - A port change can wake the device from halt.
// - A lasting mismatch keeps setting the change flag.
// - Software reads or writes the port, then clears the change flag.
// - A pin change exactly at a port read in phase two still sets the change flag.
// - Pin 0 doubles as the external interrupt input.
// - In programming mode pins 6 and 7 are clock and data, Schmitt buffered.
// - Port reads return pin levels; writes go only to the output latch.
// - Bit set and clear writes read pins, modify, and write the whole byte to the latch.
// - Writes commit at cycle end; pins are sampled in phase two.
module gpc_port
    import gpc_pkg::*;
#(
    parameter int PORT_W = 8
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Port pins
    input  wire logic [7:0]  pin_in_i,
    output logic      [7:0]  pin_out_o,
    output logic      [7:0]  pin_oe_o,
    output logic      [7:0]  pullup_on_o,
    // Programming mode
    input  wire logic        prog_mode_i,
    output logic             prog_clock_o,
    output logic             prog_data_o,
    // Interrupt and wake
    output logic             change_flag_o,
    output logic             change_irq_o,
    output logic             wake_o,
    output logic             ext_irq_o
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (PORT_W != 8) begin : g_chk
        $error("gpc_port: only an eight-bit port is supported");
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Index match, upper address bits must be clear
    function automatic logic hit(input logic [11:0] adr, input logic [7:0] idx);
        hit = (adr[11:10] == 2'h0) && (adr[9:2] == idx);
    endfunction

    // Access that counts as touching the port data
    function automatic logic port_class(input logic [11:0] adr);
        port_class = hit(adr, `GPC_IDX_PORT) || hit(adr, `GPC_IDX_BSET)
                   || hit(adr, `GPC_IDX_BCLR);
    endfunction

    // ----------------------------------------------------------------
    // Phase sequencer and pin synchroniser
    // ----------------------------------------------------------------
    gpc_phase_if ph ();

    gpc_phase_gen u_phase (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ph    (ph)
    );

    logic [8:0] sync_lvl;
    logic [7:0] pin_s;
    logic       prog_s;

    // Pins and programming strap pass two flops
    gpc_sync #(.W(9)) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({prog_mode_i, pin_in_i}),
        .sync_o  (sync_lvl)
    );

    assign pin_s  = sync_lvl[7:0];
    assign prog_s = sync_lvl[8];

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0] latch;        // Output latch
    logic [7:0] oe;           // Inverse of pin_direction
    logic [7:0] option_cfg;   // option_config
    logic [7:0] ref_lvl;      // Reference for change compare
    logic [7:0] samp;         // Pins sampled for the current access
    logic       change_flag;
    logic       change_en;

    // ----------------------------------------------------------------
    // Bus access sequencing
    // ----------------------------------------------------------------
    logic active;
    logic req;
    logic sample_now;
    logic commit;
    logic wr_commit;
    logic wr_lane0;

    // New request waits for the next cycle start
    assign req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign sample_now = active && ph.phase_two;
    assign commit     = active && ph.phase_four;
    assign wr_commit  = commit && wb_we_i;
    assign wr_lane0   = wr_commit && wb_sel_i[0];

    // Access runs across one whole instruction cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active <= 1'b0;
        end else if (!active && req && ph.phase_one) begin
            active <= 1'b1;
        end else if (commit) begin
            active <= 1'b0;
        end
    end

    // Ack for one cycle at the end of the cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= commit;
        end
    end

    // ----------------------------------------------------------------
    // Pin sampling and change reference
    // ----------------------------------------------------------------

    // Pins read early in the cycle, before any write lands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            samp <= 8'h00;
        end else if (sample_now) begin
            samp <= pin_s;
        end
    end

    // Any port read or write refreshes the reference, ending a mismatch;
    // a pin moving in this very cycle is still flagged, as the compare sees the old reference
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_lvl <= 8'h00;
        end else if (sample_now && port_class(wb_adr_i)) begin
            ref_lvl <= pin_s;
        end
    end

    // ----------------------------------------------------------------
    // Output latch and direction
    // ----------------------------------------------------------------

    // Bit set and clear act on pin levels, so inputs overwrite the latch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch <= `GPC_RST_LATCH;
        end else if (wr_lane0 && hit(wb_adr_i, `GPC_IDX_PORT)) begin
            latch <= wb_dat_i[7:0];
        end else if (wr_lane0 && hit(wb_adr_i, `GPC_IDX_BSET)) begin
            latch <= samp | wb_dat_i[7:0];
        end else if (wr_lane0 && hit(wb_adr_i, `GPC_IDX_BCLR)) begin
            latch <= samp & ~wb_dat_i[7:0];
        end
    end

    // Enable kept inverted so the pin driver comes from a flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oe <= ~`GPC_RST_DIR;
        end else if (wr_lane0 && hit(wb_adr_i, `GPC_IDX_DIR)) begin
            oe <= ~wb_dat_i[7:0];
        end
    end

    // Option register, only bit 7 is used by this port
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            option_cfg <= `GPC_RST_OPTION;
        end else if (wr_lane0 && hit(wb_adr_i, `GPC_IDX_OPTION)) begin
            option_cfg <= wb_dat_i[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Change detection
    // ----------------------------------------------------------------
    logic [3:0] mismatch;
    logic       change_cond;
    logic       flag_clr;

    // Upper pins set as inputs only
    assign mismatch    = (pin_s[7:`GPC_MON_LO] ^ ref_lvl[7:`GPC_MON_LO])
                       & ~oe[7:`GPC_MON_LO];
    assign change_cond = |mismatch;
    assign flag_clr    = wr_lane0 && hit(wb_adr_i, `GPC_IDX_CHG)
                       && wb_dat_i[`GPC_CHG_FLAG];

    // Set wins over a software clear while mismatch lasts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            change_flag <= 1'b0;
        end else if (change_cond) begin
            change_flag <= 1'b1;
        end else if (flag_clr) begin
            change_flag <= 1'b0;
        end
    end

    // Change enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            change_en <= 1'b0;
        end else if (wr_lane0 && hit(wb_adr_i, `GPC_IDX_CHG)) begin
            change_en <= wb_dat_i[`GPC_CHG_EN];
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [7:0] rd_byte;

    // Unmapped and write-only indices read as zero
    always_comb begin
        rd_byte = 8'h00;
        if (hit(wb_adr_i, `GPC_IDX_PORT)) begin
            rd_byte = samp;
        end else if (hit(wb_adr_i, `GPC_IDX_OPTION)) begin
            rd_byte = option_cfg;
        end else if (hit(wb_adr_i, `GPC_IDX_DIR)) begin
            rd_byte = ~oe;
        end else if (hit(wb_adr_i, `GPC_IDX_CHG)) begin
            rd_byte[`GPC_CHG_FLAG] = change_flag;
            rd_byte[`GPC_CHG_EN]   = change_en;
        end
    end

    // Data presented with ack, zero otherwise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (commit && !wb_we_i) begin
            wb_dat_o <= {24'h00_0000, rd_byte};
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Pin drive and pull-ups
    // ----------------------------------------------------------------

    // Outside circuits must not fight a driven pin; no guard here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_out_o <= `GPC_RST_LATCH;
            pin_oe_o  <= 8'h00;
        end else begin
            pin_out_o <= latch;
            pin_oe_o  <= oe;
        end
    end

    // Shared active-low enable, masked per output pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pullup_on_o <= 8'h00;
        end else begin
            pullup_on_o <= {8{~option_cfg[`GPC_OPT_PULLUP_N]}} & ~oe;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt, wake and alternate functions
    // ----------------------------------------------------------------

    // Request only with flag and enable both set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            change_flag_o <= 1'b0;
            change_irq_o  <= 1'b0;
        end else begin
            change_flag_o <= change_flag;
            change_irq_o  <= change_flag && change_en;
        end
    end

    // Wake follows the raw condition so a halted core sees it early
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= (change_cond || change_flag) && change_en;
        end
    end

    // Pin 0 level to the external edge logic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_irq_o <= 1'b0;
        end else begin
            ext_irq_o <= pin_s[`GPC_EXT_IRQ_BIT];
        end
    end

    // Programming lines; hysteresis lives in the pad, not here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prog_clock_o <= 1'b0;
            prog_data_o  <= 1'b0;
        end else begin
            prog_clock_o <= prog_s && pin_s[`GPC_PROG_CLK_BIT];
            prog_data_o  <= prog_s && pin_s[`GPC_PROG_DAT_BIT];
        end
    end

endmodule // gpc_port

// ### logic/gpc_consts.svh
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define GPC_IDX_PORT        8'h06
`define GPC_IDX_OPTION      8'h81
`define GPC_IDX_DIR         8'h86
`define GPC_IDX_CHG         8'h0B
`define GPC_IDX_BSET        8'h0C
`define GPC_IDX_BCLR        8'h0D

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GPC_RST_OPTION      8'hFF
`define GPC_RST_DIR         8'hFF
`define GPC_RST_LATCH       8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GPC_OPT_PULLUP_N    7
`define GPC_CHG_FLAG        0
`define GPC_CHG_EN          1
`define GPC_EXT_IRQ_BIT     0
`define GPC_PROG_CLK_BIT    6
`define GPC_PROG_DAT_BIT    7
`define GPC_MON_LO          4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define GPC_CLK_PERIOD_NS   100
`define GPC_INSTR_CYCLE_NS  400
`define GPC_PHASE_CYCLES    (`GPC_INSTR_CYCLE_NS / `GPC_CLK_PERIOD_NS)

`endif

// ### logic/gpc_pkg.sv
package gpc_pkg;

    // Instruction cycle phases, Gray coded along the ring
    typedef enum logic [1:0] {
        GPC_PH1 = 2'h0,
        GPC_PH2 = 2'h1,
        GPC_PH3 = 2'h3,
        GPC_PH4 = 2'h2
    } gpc_phase_t;

endpackage

// ### logic/gpc_phase_if.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Instruction cycle phase strobes
// ----------------------------------------------------------------
interface gpc_phase_if;
    logic phase_one;
    logic phase_two;
    logic phase_four;

    modport src (output phase_one, output phase_two, output phase_four);
    modport snk (input phase_one, input phase_two, input phase_four);
endinterface // gpc_phase_if

// ### logic/gpc_phase_gen.sv
`timescale 1ns/10ps
`include "gpc_consts.svh"
// ----------------------------------------------------------------
// Four phase sequencer, one phase per clock
// ----------------------------------------------------------------
module gpc_phase_gen
    import gpc_pkg::*;
(
    // Clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    // Phase strobes
    gpc_phase_if.src   ph
);
    gpc_phase_t state;
    gpc_phase_t next_state;

    // Ring is fixed at four states
    if (`GPC_PHASE_CYCLES != 4) begin : g_chk
        $error("gpc_phase_gen: instruction cycle must be four clocks");
    end

    // Ring advance
    always_comb begin
        unique case (state)
            GPC_PH1: next_state = GPC_PH2;
            GPC_PH2: next_state = GPC_PH3;
            GPC_PH3: next_state = GPC_PH4;
            GPC_PH4: next_state = GPC_PH1;
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= GPC_PH1;
        end else begin
            state <= next_state;
        end
    end

    // Strobe decode
    assign ph.phase_one  = (state == GPC_PH1);
    assign ph.phase_two  = (state == GPC_PH2);
    assign ph.phase_four = (state == GPC_PH4);
endmodule // gpc_phase_gen

// ### logic/gpc_sync.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Two flop synchroniser for pin levels
// ----------------------------------------------------------------
module gpc_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta;

    if (W < 1) begin : g_chk
        $error("gpc_sync: width must be positive");
    end

    // First stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule // gpc_sync

// ### verif/gpc_port_sva.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Port behaviour checker, top ports only
// ----------------------------------------------------------------
module gpc_port_sva (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    // Pins and events
    input  wire logic [7:0]  pin_in_i,
    input  wire logic [7:0]  pin_oe_o,
    input  wire logic [7:0]  pullup_on_o,
    input  wire logic        change_flag_o,
    input  wire logic        change_irq_o,
    input  wire logic        wake_o,
    input  wire logic        ext_irq_o
);
    logic [2:0] run_cnt;

    // Cycles since reset, saturating; keeps pipeline checks off reset-time flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_cnt <= 3'h0;
        end else if (run_cnt != 3'h7) begin
            run_cnt <= run_cnt + 3'h1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_req; $rose(wb_stb_i) && wb_cyc_i; endsequence
    sequence s_ack; ##[1:8] wb_ack_o; endsequence
    sequence s_pin0_calm; (run_cnt == 3'h7) ##0 $stable(pin_in_i[0]) [*4]; endsequence

    property p_ack_bound; s_req |-> s_ack; endproperty
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
    property p_pull_out; (pullup_on_o & pin_oe_o) == 8'h00; endproperty
    property p_pull_all; pullup_on_o == 8'h00 || (pullup_on_o | pin_oe_o) == 8'hFF; endproperty
    property p_pull_reset; run_cnt <= 3'h1 |-> pullup_on_o == 8'h00 && pin_oe_o == 8'h00; endproperty
    property p_irq_gate; change_irq_o |-> change_flag_o; endproperty
    property p_wake; change_irq_o |-> wake_o; endproperty
    property p_flag_hold; change_flag_o && !wb_cyc_i && !$past(wb_cyc_i) |=> change_flag_o; endproperty
    property p_ext_irq; s_pin0_calm |-> ext_irq_o == pin_in_i[0]; endproperty

    a_ack_bound: assert property (p_ack_bound) else $error("ack late");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    a_pull_out: assert property (p_pull_out) else $error("pull-up on a driven pin");
    a_pull_all: assert property (p_pull_all) else $error("pull-ups not shared");
    a_pull_reset: assert property (p_pull_reset) else $error("pins not released at reset");
    a_irq_gate: assert property (p_irq_gate) else $error("request without flag");
    a_wake: assert property (p_wake) else $error("request without wake");
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost without access");
    a_ext_irq: assert property (p_ext_irq) else $error("external irq not pin 0");
endmodule // gpc_port_sva

bind gpc_port gpc_port_sva gpc_port_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_in_i(pin_in_i), .pin_oe_o(pin_oe_o),
    .pullup_on_o(pullup_on_o), .change_flag_o(change_flag_o), .change_irq_o(change_irq_o), .wake_o(wake_o),
    .ext_irq_o(ext_irq_o));

// ### verif/gpc_pin_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Board side: drivers, pull-ups, floating lines
// ----------------------------------------------------------------
module gpc_pin_model (
    // Clock
    input  wire logic       clk_i,
    // Device side
    input  wire logic [7:0] pin_out_i,
    input  wire logic [7:0] pin_oe_i,
    input  wire logic [7:0] pullup_on_i,
    // Board drivers
    input  wire logic [7:0] ext_drv_i,
    input  wire logic [7:0] ext_en_i,
    // Resolved levels
    output logic      [7:0] level_o
);
    logic [7:0] float_pat = 8'h55;

    // Undriven lines wander, so nothing leans on a stale level
    always_ff @(posedge clk_i) begin
        float_pat <= ~float_pat;
    end

    // Device driver wins; the board only drives released pins
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe_i[i]) begin
                level_o[i] = pin_out_i[i];
            end else if (ext_en_i[i]) begin
                level_o[i] = ext_drv_i[i];
            end else if (pullup_on_i[i]) begin
                level_o[i] = 1'b1;
            end else begin
                level_o[i] = float_pat[i];
            end
        end
    end
endmodule // gpc_pin_model

// ### verif/testbench.sv
`timescale 1ns/10ps
`include "gpc_consts.svh"
module testbench;
    // ----------------------------------------------------------------
    // Addresses and bench state
    // ----------------------------------------------------------------
    localparam logic [11:0] adr_port = {2'h0, `GPC_IDX_PORT, 2'h0};
    localparam logic [11:0] adr_opt  = {2'h0, `GPC_IDX_OPTION, 2'h0};
    localparam logic [11:0] adr_dir  = {2'h0, `GPC_IDX_DIR, 2'h0};
    localparam logic [11:0] adr_chg  = {2'h0, `GPC_IDX_CHG, 2'h0};
    localparam logic [11:0] adr_bclr = {2'h0, `GPC_IDX_BCLR, 2'h0};
    localparam logic [11:0] adr_none = 12'h3FC;
    logic        clk_i     = 1'b0;
    logic        rst_i     = 1'b1;
    logic        wb_cyc    = 1'b0;
    logic        wb_stb    = 1'b0;
    logic        wb_we     = 1'b0;
    logic [11:0] wb_adr    = 12'h000;
    logic [31:0] wb_wdat   = 32'h0000_0000;
    logic [7:0]  ext_drv   = 8'h00;
    logic [7:0]  ext_en    = 8'hFF;
    logic        prog_mode = 1'b0;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic [7:0]  pin_lvl, pin_out, pin_oe, pull_on;
    logic        prog_clk, prog_dat, chg_flag, chg_irq, wake, ext_irq;
    int          num_errors = 0;
    int          checks_done = 0;

    // Free running 10 MHz clock
    initial begin
        forever #50 clk_i = ~clk_i;
    end

    gpc_port #(.PORT_W(8)) gpc_port_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .pin_in_i(pin_lvl), .pin_out_o(pin_out), .pin_oe_o(pin_oe), .pullup_on_o(pull_on),
        .prog_mode_i(prog_mode), .prog_clock_o(prog_clk), .prog_data_o(prog_dat), .change_flag_o(chg_flag),
        .change_irq_o(chg_irq), .wake_o(wake), .ext_irq_o(ext_irq));

    gpc_pin_model gpc_pin_model_inst (.clk_i(clk_i), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
        .pullup_on_i(pull_on), .ext_drv_i(ext_drv), .ext_en_i(ext_en), .level_o(pin_lvl));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One classic cycle; request held until ack is sampled high, however long;
    // only the watchdog ends a hung wait
    task automatic wb_io(input logic we, input logic [11:0] adr, input logic [7:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= adr;
        wb_wdat <= {24'h00_0000, wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1);
        rd = wb_rdat;
        // Up to four edges to reach a cycle start, four more to the ack
        chk("wb_ack edges", 32'h0000_0001, {31'h0000_0000, (n <= 8)});
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] adr, input logic [7:0] wd);
        logic [31:0] rd;
        wb_io(1'b1, adr, wd, rd);
    endtask

    task automatic rd_chk(input string what, input logic [11:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wb_io(1'b0, adr, 8'h00, rd);
        chk(what, exp, rd);
    endtask

    // Lets the pin synchroniser and output flops catch up
    task automatic settle;
        repeat (8) @(posedge clk_i);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the tests need
    initial begin : watchdog
        for (int c = 0; c < 5000; c++) begin
            @(posedge clk_i);
        end
        num_errors++;
        final_report();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin : main
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("option", adr_opt, 32'h0000_00FF);
        rd_chk("direction", adr_dir, 32'h0000_00FF);
        rd_chk("change", adr_chg, 32'h0000_0000);
        rd_chk("unmapped", adr_none, 32'h0000_0000);
        chk("pin_oe", 32'h0000_0000, {24'h00_0000, pin_oe});
        chk("pullup", 32'h0000_0000, {24'h00_0000, pull_on});
        $display("test reset done");
        wr(adr_opt, 8'h7F);
        wr(adr_dir, 8'hF0);
        rd_chk("direction", adr_dir, 32'h0000_00F0);
        settle();
        chk("pin_oe", 32'h0000_000F, {24'h00_0000, pin_oe});
        chk("pullup", 32'h0000_00F0, {24'h00_0000, pull_on});
        ext_en <= 8'h00;
        settle();
        rd_chk("port pulled", adr_port, 32'h0000_00F0);
        wr(adr_chg, 8'h01);
        settle();
        chk("flag", 32'h0000_0000, {31'h0000_0000, chg_flag});
        ext_drv <= 8'h70;
        ext_en  <= 8'hF0;
        settle();
        chk("flag", 32'h0000_0001, {31'h0000_0000, chg_flag});
        chk("irq off", 32'h0000_0000, {31'h0000_0000, chg_irq});
        chk("wake off", 32'h0000_0000, {31'h0000_0000, wake});
        $display("test pull-ups and change done");
        wr(adr_port, 8'hA4);
        settle();
        chk("latch", 32'h0000_00A4, {24'h00_0000, pin_out});
        rd_chk("port pins", adr_port, 32'h0000_0074);
        wr(adr_bclr, 8'h00);
        settle();
        chk("latch rmw", 32'h0000_0074, {24'h00_0000, pin_out});
        $display("test latch done");
        wr(adr_chg, 8'h02);
        settle();
        chk("irq", 32'h0000_0001, {31'h0000_0000, chg_irq});
        chk("wake", 32'h0000_0001, {31'h0000_0000, wake});
        ext_drv <= 8'h30;
        settle();
        wr(adr_chg, 8'h03);
        settle();
        chk("flag held", 32'h0000_0001, {31'h0000_0000, chg_flag});
        rd_chk("port", adr_port, 32'h0000_0034);
        wr(adr_chg, 8'h03);
        settle();
        chk("flag clear", 32'h0000_0000, {31'h0000_0000, chg_flag});
        chk("irq clear", 32'h0000_0000, {31'h0000_0000, chg_irq});
        $display("test clear done");
        ext_drv <= 8'h39;
        wr(adr_port, 8'h39);
        wr(adr_dir, 8'h0F);
        ext_en <= 8'h0F;
        settle();
        chk("ext irq", 32'h0000_0001, {31'h0000_0000, ext_irq});
        ext_drv <= 8'h06;
        settle();
        chk("ext irq", 32'h0000_0000, {31'h0000_0000, ext_irq});
        wr(adr_port, 8'hF6);
        settle();
        chk("flag outputs", 32'h0000_0000, {31'h0000_0000, chg_flag});
        $display("test exclusion done");
        prog_mode <= 1'b1;
        settle();
        chk("prog clock", 32'h0000_0001, {31'h0000_0000, prog_clk});
        chk("prog data", 32'h0000_0001, {31'h0000_0000, prog_dat});
        wr(adr_port, 8'h86);
        settle();
        chk("prog clock", 32'h0000_0000, {31'h0000_0000, prog_clk});
        chk("prog data", 32'h0000_0001, {31'h0000_0000, prog_dat});
        $display("test programming pins done");
        final_report();
    end
endmodule // testbench
